// [hdl/dual_serial_host_interface.sv]
/*
 * SPI and I2C target front end with a 128 x 16 register array.
 * Assumes SCLK is the link clock, frame select stays high at least
 * four reference clocks between frames, and I2C pins are slow enough
 * to be oversampled by the 50 MHz reference clock.
 */
`timescale 1ns/1ns
`default_nettype none
module dual_serial_host_interface #(
  parameter int REG_DEPTH = serial_if_pkg::REG_COUNT
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_sclk,
  input wire logic i_frame_sel_n,
  input wire logic i_sdi,
  output logic o_sdo,
  output logic o_sdo_oe,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic [1:0] i_addr_select_pin,
  output logic o_wr_valid,
  output logic [6:0] o_wr_addr,
  output logic [15:0] o_wr_data,
  output logic o_soft_reset,
  output logic [1:0] o_iface_sel,
  output logic o_readback_output_enable,
  output logic o_readback_edge_select
);
  logic rst_s1_q, rst_q;
  logic [15:0] mem [REG_DEPTH];
  serial_if_pkg::iface_type iface_q;
  logic cfg_en_q, cfg_edge_q;
  logic rb_pending_q;
  logic [23:0] rb_word_q;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_q <= rst_s1_q;
    end
  end

  // Link side, clocked by SCLK. Frame select high forces a fresh frame.
  logic fresh_q, got24_q, en_s1_q, en_s2_q, edge_s1_q, edge_s2_q;
  logic [4:0] rem_q;
  logic [23:0] rx_q, first_q, tx_q;
  logic sdo_fall_q, sdo_rise_q, oe_q;
  logic [23:0] load_word;

  assign load_word = rb_pending_q ? rb_word_q : 24'h000000;

  // Reset also marks a fresh frame, so the first frame never sees an unknown.
  always_ff @(negedge i_sclk or posedge i_frame_sel_n or negedge rst_q) begin
    if (!rst_q) begin
      fresh_q <= 1'b1;
    end else if (i_frame_sel_n) begin
      fresh_q <= 1'b1;
    end else begin
      fresh_q <= 1'b0;
    end
  end

  always_ff @(negedge i_sclk or negedge rst_q) begin
    if (!rst_q) begin
      rem_q <= 5'h00;
      got24_q <= 1'b0;
      rx_q <= 24'h000000;
      first_q <= 24'h000000;
    end else if (!i_frame_sel_n) begin
      rx_q <= {rx_q[22:0], i_sdi};
      if (fresh_q) begin
        rem_q <= serial_if_pkg::REM_FRESH;
        got24_q <= 1'b0;
      end else if (rem_q == serial_if_pkg::LAST_IDX) begin
        rem_q <= 5'h00;
        got24_q <= 1'b1;
        if (!got24_q) begin
          first_q <= {rx_q[22:0], i_sdi};
        end
      end else begin
        rem_q <= rem_q + 5'h01;
      end
    end
  end

  always_ff @(negedge i_sclk or negedge rst_q) begin
    if (!rst_q) begin
      en_s1_q <= 1'b0;
      en_s2_q <= 1'b0;
      edge_s1_q <= 1'b0;
      edge_s2_q <= 1'b0;
    end else begin
      en_s1_q <= cfg_en_q;
      en_s2_q <= en_s1_q;
      edge_s1_q <= cfg_edge_q;
      edge_s2_q <= edge_s1_q;
    end
  end

  // The readback word is loaded on the first edge and shifted out; SDI echoes 24 bits later.
  always_ff @(negedge i_sclk or negedge rst_q) begin
    if (!rst_q) begin
      tx_q <= 24'h000000;
      sdo_fall_q <= 1'b0;
    end else if (!i_frame_sel_n) begin
      if (fresh_q) begin
        tx_q <= {load_word[22:0], i_sdi};
        sdo_fall_q <= load_word[23];
      end else begin
        tx_q <= {tx_q[22:0], i_sdi};
        sdo_fall_q <= tx_q[23];
      end
    end
  end

  always_ff @(posedge i_sclk or negedge rst_q) begin
    if (!rst_q) begin
      sdo_rise_q <= 1'b0;
    end else begin
      sdo_rise_q <= sdo_fall_q;
    end
  end

  always_ff @(negedge i_sclk or negedge rst_q or posedge i_frame_sel_n) begin
    if (!rst_q) begin
      oe_q <= 1'b0;
    end else if (i_frame_sel_n) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= en_s2_q;
    end
  end

  assign o_sdo = edge_s2_q ? sdo_fall_q : sdo_rise_q;
  assign o_sdo_oe = oe_q;

  // Reference side: pin synchronisers.
  logic sel_s1_q, sel_s2_q, sel_s3_q;
  logic scl_s1_q, scl_s2_q, scl_s3_q, sda_s1_q, sda_s2_q, sda_s3_q;
  logic [1:0] pin_s1_q, pin_s2_q;

  always_ff @(posedge i_ref_clk or negedge rst_q) begin
    if (!rst_q) begin
      sel_s1_q <= 1'b1;
      sel_s2_q <= 1'b1;
      sel_s3_q <= 1'b1;
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
      pin_s1_q <= 2'h0;
      pin_s2_q <= 2'h0;
    end else begin
      sel_s1_q <= i_frame_sel_n;
      sel_s2_q <= sel_s1_q;
      sel_s3_q <= sel_s2_q;
      scl_s1_q <= i_scl;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= i_sda;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
      pin_s1_q <= i_addr_select_pin;
      pin_s2_q <= pin_s1_q;
    end
  end

  // Link words are stable here: SCLK is ignored while frame select is high.
  logic frame_end, frame_begin, frame_ok;
  logic [23:0] word_sel;
  assign frame_end = sel_s2_q && !sel_s3_q;
  assign frame_begin = !sel_s2_q && sel_s3_q;
  assign word_sel = cfg_en_q ? rx_q : first_q;
  assign frame_ok = frame_end && iface_q != serial_if_pkg::IF_I2C &&
    got24_q && (!cfg_en_q || rem_q == 5'h00);

  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise = scl_s2_q && !scl_s3_q;
  assign scl_fall = !scl_s2_q && scl_s3_q;
  assign start_det = scl_s2_q && scl_s3_q && !sda_s2_q && sda_s3_q;
  assign stop_det = scl_s2_q && scl_s3_q && sda_s2_q && !sda_s3_q;

  always_ff @(posedge i_ref_clk or negedge rst_q) begin
    if (!rst_q) begin
      iface_q <= serial_if_pkg::IF_NONE;
    end else if (iface_q == serial_if_pkg::IF_NONE) begin
      if (frame_begin) begin
        iface_q <= serial_if_pkg::IF_SPI;
      end else if (start_det) begin
        iface_q <= serial_if_pkg::IF_I2C;
      end
    end
  end

  // I2C target engine.
  serial_if_pkg::i2c_state_type ist_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q, upper_q;
  logic [1:0] idx_q, addr_pin_q;
  logic rd_q, gc_q, sda_oe_q, soft_q;
  logic [6:0] cmd_q, own_addr;
  logic addr_hit, i2c_wr;
  logic [15:0] rd_reg;
  assign own_addr = {serial_if_pkg::I2C_FIXED_HI, 1'b0, addr_pin_q};
  assign addr_hit = sh_q[7:1] == own_addr ||
    (sh_q[7:1] == serial_if_pkg::I2C_BCAST && !sh_q[0]) ||
    sh_q == serial_if_pkg::GC_ADDR;
  assign rd_reg = mem[cmd_q];
  assign i2c_wr = ist_q == serial_if_pkg::I_ACK && scl_fall && !rd_q &&
    !gc_q && idx_q == serial_if_pkg::IDX_LOWER;

  always_ff @(posedge i_ref_clk or negedge rst_q) begin
    if (!rst_q) begin
      ist_q <= serial_if_pkg::I_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      upper_q <= 8'h00;
      idx_q <= serial_if_pkg::IDX_ADDR;
      addr_pin_q <= 2'h0;
      rd_q <= 1'b0;
      gc_q <= 1'b0;
      cmd_q <= 7'h00;
      sda_oe_q <= 1'b0;
      soft_q <= 1'b0;
    end else begin
      soft_q <= 1'b0;
      if (iface_q == serial_if_pkg::IF_SPI) begin
        ist_q <= serial_if_pkg::I_IDLE;
        sda_oe_q <= 1'b0;
      end else if (start_det) begin
        ist_q <= serial_if_pkg::I_RECV;
        bit_q <= 4'h0;
        idx_q <= serial_if_pkg::IDX_ADDR;
        gc_q <= 1'b0;
        sda_oe_q <= 1'b0;
        addr_pin_q <= pin_s2_q;
      end else if (stop_det) begin
        ist_q <= serial_if_pkg::I_IDLE;
        sda_oe_q <= 1'b0;
      end else begin
        unique case (ist_q)
          serial_if_pkg::I_IDLE: begin
          end
          serial_if_pkg::I_RECV: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_s2_q};
              bit_q <= bit_q + 4'h1;
            end else if (scl_fall && bit_q == serial_if_pkg::BYTE_BITS) begin
              bit_q <= 4'h0;
              if (idx_q == serial_if_pkg::IDX_ADDR) begin
                rd_q <= sh_q[0];
                gc_q <= sh_q == serial_if_pkg::GC_ADDR;
                sda_oe_q <= addr_hit;
                ist_q <= addr_hit ? serial_if_pkg::I_ACK :
                  serial_if_pkg::I_IDLE;
              end else if (gc_q && sh_q != serial_if_pkg::GC_RESET) begin
                ist_q <= serial_if_pkg::I_IDLE;
              end else begin
                sda_oe_q <= 1'b1;
                ist_q <= serial_if_pkg::I_ACK;
                if (idx_q == serial_if_pkg::IDX_CMD) begin
                  cmd_q <= sh_q[6:0];
                end
                if (idx_q == serial_if_pkg::IDX_UPPER) begin
                  upper_q <= sh_q;
                end
              end
            end
          end
          serial_if_pkg::I_ACK: begin
            if (scl_rise && gc_q && idx_q == serial_if_pkg::IDX_CMD) begin
              soft_q <= 1'b1;
            end
            if (scl_fall) begin
              sda_oe_q <= 1'b0;
              bit_q <= 4'h0;
              if (rd_q) begin
                idx_q <= serial_if_pkg::IDX_UPPER;
                sh_q <= {rd_reg[14:8], 1'b0};
                sda_oe_q <= !rd_reg[15];
                bit_q <= 4'h1;
                ist_q <= serial_if_pkg::I_SEND;
              end else begin
                idx_q <= idx_q == serial_if_pkg::IDX_LOWER ?
                  serial_if_pkg::IDX_UPPER : idx_q + 2'h1;
                ist_q <= serial_if_pkg::I_RECV;
              end
            end
          end
          serial_if_pkg::I_SEND: begin
            if (scl_fall) begin
              if (bit_q == serial_if_pkg::BYTE_BITS) begin
                sda_oe_q <= 1'b0;
                ist_q <= serial_if_pkg::I_RACK;
              end else begin
                sda_oe_q <= !sh_q[7];
                sh_q <= {sh_q[6:0], 1'b0};
                bit_q <= bit_q + 4'h1;
              end
            end
          end
          serial_if_pkg::I_RACK: begin
            if (scl_rise && sda_s2_q) begin
              ist_q <= serial_if_pkg::I_IDLE;
            end else if (scl_fall) begin
              idx_q <= idx_q == serial_if_pkg::IDX_UPPER ?
                serial_if_pkg::IDX_LOWER : serial_if_pkg::IDX_UPPER;
              if (idx_q == serial_if_pkg::IDX_UPPER) begin
                sh_q <= {rd_reg[6:0], 1'b0};
                sda_oe_q <= !rd_reg[7];
              end else begin
                sh_q <= {rd_reg[14:8], 1'b0};
                sda_oe_q <= !rd_reg[15];
              end
              bit_q <= 4'h1;
              ist_q <= serial_if_pkg::I_SEND;
            end
          end
        endcase
      end
    end
  end

  // Register array and write path shared by both protocols.
  logic spi_wr, wr_en;
  logic [6:0] wr_addr;
  logic [15:0] wr_data;
  assign spi_wr = frame_ok && !word_sel[serial_if_pkg::DIR_BIT];
  assign wr_en = spi_wr || i2c_wr;
  assign wr_addr = spi_wr ?
    word_sel[serial_if_pkg::ADDR_HI:serial_if_pkg::ADDR_LO] : cmd_q;
  assign wr_data = spi_wr ? word_sel[15:0] : {upper_q, sh_q};

  always_ff @(posedge i_ref_clk or negedge rst_q) begin
    if (!rst_q) begin
      for (int i = 0; i < REG_DEPTH; i++) begin
        mem[i] <= serial_if_pkg::REG_RESET;
      end
    end else if (soft_q) begin
      for (int i = 0; i < REG_DEPTH; i++) begin
        mem[i] <= serial_if_pkg::REG_RESET;
      end
    end else if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_q) begin
    if (!rst_q) begin
      cfg_en_q <= 1'b0;
      cfg_edge_q <= 1'b0;
    end else if (soft_q) begin
      cfg_en_q <= 1'b0;
      cfg_edge_q <= 1'b0;
    end else if (wr_en && wr_addr == serial_if_pkg::CFG_ADDR) begin
      cfg_en_q <= wr_data[serial_if_pkg::CFG_EN_BIT];
      cfg_edge_q <= wr_data[serial_if_pkg::CFG_EDGE_BIT];
    end
  end

  // A completed frame replaces the pending readback; aborted ones do not.
  always_ff @(posedge i_ref_clk or negedge rst_q) begin
    if (!rst_q) begin
      rb_pending_q <= 1'b0;
      rb_word_q <= 24'h000000;
    end else if (frame_ok) begin
      rb_pending_q <= cfg_en_q && word_sel[serial_if_pkg::DIR_BIT];
      rb_word_q <= {word_sel[23:16],
        mem[word_sel[serial_if_pkg::ADDR_HI:serial_if_pkg::ADDR_LO]]};
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_q) begin
    if (!rst_q) begin
      o_wr_valid <= 1'b0;
      o_wr_addr <= 7'h00;
      o_wr_data <= 16'h0000;
      o_soft_reset <= 1'b0;
      o_sda_out <= 1'b0;
      o_sda_oe <= 1'b0;
      o_iface_sel <= 2'h0;
      o_readback_output_enable <= 1'b0;
      o_readback_edge_select <= 1'b0;
    end else begin
      o_wr_valid <= wr_en;
      o_wr_addr <= wr_addr;
      o_wr_data <= wr_data;
      o_soft_reset <= soft_q;
      o_sda_out <= 1'b0;
      o_sda_oe <= sda_oe_q;
      o_iface_sel <= iface_q;
      o_readback_output_enable <= cfg_en_q;
      o_readback_edge_select <= cfg_edge_q;
    end
  end

  a_sdo_hiz: assert property (@(posedge i_ref_clk) disable iff (!rst_q)
    i_frame_sel_n |-> !o_sdo_oe) else $error("SDO driven while frame high");
  a_short_drop: assert property (@(posedge i_ref_clk) disable iff (!rst_q)
    frame_end && !got24_q |=> !o_wr_valid) else $error("short frame used");
  a_spi_write: assert property (@(posedge i_ref_clk) disable iff (!rst_q)
    spi_wr |=> o_wr_valid && o_wr_addr == $past(word_sel[22:16]) &&
    o_wr_data == $past(word_sel[15:0])) else $error("SPI write wrong");
  a_read_nowrite: assert property (@(posedge i_ref_clk) disable iff (!rst_q)
    frame_ok && word_sel[23] |=> !o_wr_valid) else $error("read wrote");
  a_rb_echo: assert property (@(posedge i_ref_clk) disable iff (!rst_q)
    frame_ok && cfg_en_q && word_sel[23] |=> rb_pending_q &&
    rb_word_q[23:16] == $past(word_sel[23:16])) else $error("no echo");
  a_4w_partial: assert property (@(posedge i_ref_clk) disable iff (!rst_q)
    frame_end && cfg_en_q && rem_q != 5'h00 |=> !o_wr_valid && $stable(rb_word_q))
    else $error("partial frame used");
  a_gc_reset: assert property (@(posedge i_ref_clk) disable iff (!rst_q)
    ist_q == serial_if_pkg::I_ACK && gc_q && idx_q == 2'h1 && scl_rise &&
    !start_det && !stop_det |=> ##1 o_soft_reset) else $error("no reset");
  a_addr_nack: assert property (@(posedge i_ref_clk) disable iff (!rst_q)
    ist_q == serial_if_pkg::I_RECV && idx_q == 2'h0 && scl_fall &&
    bit_q == 4'h8 && !addr_hit && !stop_det |=> ##1 !o_sda_oe)
    else $error("acked foreign address");
  a_stop_release: assert property (@(posedge i_ref_clk) disable iff (!rst_q)
    stop_det && !start_det |=> ist_q == serial_if_pkg::I_IDLE ##1 !o_sda_oe)
    else $error("bus held after stop");
  a_iface_lock: assert property (@(posedge i_ref_clk) disable iff (!rst_q)
    iface_q != serial_if_pkg::IF_NONE |=> $stable(iface_q))
    else $error("interface changed");
endmodule
`default_nettype wire

// [hdl/serial_if_pkg.sv]
/*
 * Shared constants and types for the dual serial host interface.
 * Assumes a 24-bit SPI frame and 7-bit I2C target addressing.
 */
package serial_if_pkg;
  localparam int FRAME_BITS = 24;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;
  localparam int REG_COUNT = 128;
  localparam int REM_W = 5;
  localparam int DIR_BIT = 23;
  localparam int ADDR_HI = 22;
  localparam int ADDR_LO = 16;
  localparam logic [4:0] LAST_IDX = 5'h17;
  localparam logic [4:0] REM_FRESH = 5'h01;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [6:0] CFG_ADDR = 7'h01;
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_EDGE_BIT = 1;
  localparam logic [3:0] I2C_FIXED_HI = 4'h9;
  localparam logic [6:0] I2C_BCAST = 7'h47;
  localparam logic [7:0] GC_ADDR = 8'h00;
  localparam logic [7:0] GC_RESET = 8'h06;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [1:0] IDX_ADDR = 2'h0;
  localparam logic [1:0] IDX_CMD = 2'h1;
  localparam logic [1:0] IDX_UPPER = 2'h2;
  localparam logic [1:0] IDX_LOWER = 2'h3;

  typedef enum logic [1:0] {
    IF_NONE = 2'b00,
    IF_SPI = 2'b01,
    IF_I2C = 2'b10
  } iface_type;

  typedef enum logic [2:0] {
    I_IDLE = 3'b000,
    I_RECV = 3'b001,
    I_ACK = 3'b010,
    I_SEND = 3'b011,
    I_RACK = 3'b100
  } i2c_state_type;
endpackage

// [testbench/spi_host_model.sv]
/*
 * Behavioural SPI host that frames transfers on a gated 6 ns link clock.
 * Assumes the bench calls its tasks one at a time, just after a
 * reference clock edge.
 */
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
  output logic o_sclk,
  output logic o_frame_sel_n,
  output logic o_sdi,
  input wire logic i_sdo,
  input wire logic i_sdo_oe,
  input wire logic i_edge_sel
);
  initial begin
    o_sclk = 1'b1;
    o_frame_sel_n = 1'b1;
    o_sdi = 1'b0;
  end

  // The clock stands still high outside frames; data changes while high.
  task automatic xfer(input int n, input logic [71:0] w,
                      output logic [71:0] rx, output logic oe);
    int i;
    logic e;
    rx = '0;
    oe = 1'b0;
    e = i_edge_sel;
    o_frame_sel_n = 1'b0;
    #4;
    for (i = n - 1; i >= 0; i--) begin
      o_sdi = w[i];
      #1 o_sclk = 1'b0;
      #2;
      if (e === 1'b1) begin
        rx = {rx[70:0], i_sdo};
        oe = oe | i_sdo_oe;
      end
      #1 o_sclk = 1'b1;
      #2;
      if (e !== 1'b1) begin
        rx = {rx[70:0], i_sdo};
        oe = oe | i_sdo_oe;
      end
    end
    o_frame_sel_n = 1'b1;
    o_sdi = ~o_sdi;
    #120;
  endtask

  // Toggles clock and data while the frame select is held high.
  task automatic noise(output logic oe);
    int i;
    oe = 1'b0;
    for (i = 0; i < 30; i++) begin
      o_sdi = ~o_sdi;
      #3 o_sclk = 1'b0;
      oe = oe | i_sdo_oe;
      #3 o_sclk = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
/*
 * Self-checking bench for the SPI and I2C sides of the dual serial interface.
 * Assumes the I2C pins idle high, so the interface locks to SPI until the bench resets it.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic i_ref_clk, i_rst_n, i_scl, i_sda;
  logic [1:0] i_addr_select_pin;
  wire logic sclk, fsel_n, sdi, sda_line;
  logic o_sdo, o_sdo_oe, o_sda_out, o_sda_oe, o_wr_valid, o_soft_reset;
  logic [6:0] o_wr_addr;
  logic [15:0] o_wr_data;
  logic [1:0] o_iface_sel;
  logic o_readback_output_enable, o_readback_edge_select;
  int err_count, tests_run, wr_cnt, sr_cnt, j, e;
  logic [6:0] wr_a, a, b;
  logic [15:0] wr_d, d;
  logic [15:0] mem [128];
  logic [31:0] seed, r;
  logic [71:0] rx;
  logic oe, eb;

  dual_serial_host_interface dut (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_sclk(sclk),
    .i_frame_sel_n(fsel_n), .i_sdi(sdi), .o_sdo(o_sdo),
    .o_sdo_oe(o_sdo_oe), .i_scl(i_scl), .i_sda(sda_line),
    .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
    .i_addr_select_pin(i_addr_select_pin), .o_wr_valid(o_wr_valid),
    .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data),
    .o_soft_reset(o_soft_reset), .o_iface_sel(o_iface_sel),
    .o_readback_output_enable(o_readback_output_enable),
    .o_readback_edge_select(o_readback_edge_select)
  );

  spi_host_model host (
    .o_sclk(sclk), .o_frame_sel_n(fsel_n), .o_sdi(sdi), .i_sdo(o_sdo),
    .i_sdo_oe(o_sdo_oe), .i_edge_sel(o_readback_edge_select)
  );

  // Open-drain data line: the target pulls it low when it enables its driver.
  assign sda_line = i_sda & !o_sda_oe;

  initial begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end

  always @(posedge i_ref_clk) begin
    if (o_wr_valid === 1'b1) begin
      wr_cnt++;
      wr_a = o_wr_addr;
      wr_d = o_wr_data;
    end
    if (o_soft_reset === 1'b1) begin
      sr_cnt++;
    end
  end

  // Sends one byte with SCL low around data changes, then samples the ack.
  task automatic i2c_byte(input logic [7:0] v, output logic ack);
    int k;
    for (k = 7; k >= 0; k--) begin
      #50 i_sda = v[k];
      #150 i_scl = 1'b1;
      #200 i_scl = 1'b0;
    end
    #50 i_sda = 1'b1;
    #150 i_scl = 1'b1;
    #100 ack = !sda_line;
    #100 i_scl = 1'b0;
  endtask

  // Start (stp 0) or stop (stp 1) condition, SDA moving while SCL is high.
  task automatic i2c_cond(input logic stp);
    #50 i_sda = stp ? 1'b0 : 1'b1;
    #150 i_scl = 1'b1;
    #200 i_sda = stp;
    #200 i_scl = stp;
  endtask

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [23:0] mk(input logic dr, input logic [6:0] ad,
                                     input logic [15:0] dt);
    return {dr, ad, dt};
  endfunction

  task automatic check(input logic [71:0] got, input logic [71:0] exp,
                       input string m);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  // Sends one access and checks whether exactly the expected write came.
  task automatic frame(input int n, input logic [71:0] w, input logic wr,
                       input logic [6:0] ad, input logic [15:0] dt);
    int c0;
    int k;
    c0 = wr_cnt;
    @(posedge i_ref_clk);
    #1;
    host.xfer(n, w, rx, oe);
    for (k = 0; k < 20 && wr_cnt == c0; k++) @(posedge i_ref_clk);
    repeat (4) @(posedge i_ref_clk);
    check(72'(wr_cnt - c0), 72'(wr), "write count");
    if (wr) begin
      check(72'(wr_a), 72'(ad), "write address");
      check(72'(wr_d), 72'(dt), "write data");
      mem[ad] = dt;
    end
  endtask

  task automatic pick();
    r = rnd();
    a = (r[6:0] == serial_if_pkg::CFG_ADDR) ? 7'h02 : r[6:0];
    d = r[31:16];
  endtask

  task automatic end_of_test();
    if (err_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    err_count++;
    end_of_test();
  end

  initial begin
    seed = 32'd54;
    err_count = 0;
    tests_run = 0;
    wr_cnt = 0;
    sr_cnt = 0;
    i_rst_n = 1'b0;
    i_scl = 1'b1;
    i_sda = 1'b1;
    i_addr_select_pin = 2'h1;
    for (j = 0; j < 128; j++) mem[j] = serial_if_pkg::REG_RESET;
    repeat (16) @(posedge i_ref_clk);
    #1 i_rst_n = 1'b1;
    repeat (5) @(posedge i_ref_clk);
    check(72'(o_iface_sel), 72'(serial_if_pkg::IF_NONE), "idle type");
    check(72'(o_readback_output_enable), 72'h0, "enable at reset");
    for (j = 0; j < 6; j++) begin
      pick();
      frame(24, {48'h0, mk(1'b0, a, d)}, 1'b1, a, d);
    end
    check(72'(o_iface_sel), 72'(serial_if_pkg::IF_SPI), "locked type");
    pick();
    frame(30, {42'h0, mk(1'b0, a, d), 6'h2a}, 1'b1, a, d);
    frame(23, {49'h0, mk(1'b0, a, ~d) >> 1}, 1'b0, a, d);
    frame(24, {48'h0, mk(1'b1, a, d)}, 1'b0, a, d);
    frame(24, {48'h0, mk(1'b1, a, d)}, 1'b0, a, d);
    check(72'(oe), 72'h0, "output in three-wire mode");
    for (e = 1; e >= 0; e--) begin
      eb = e[0];
      frame(24, {48'h0, mk(1'b0, serial_if_pkg::CFG_ADDR, {14'h0, eb, 1'b1})},
            1'b1, serial_if_pkg::CFG_ADDR, {14'h0, eb, 1'b1});
      check(72'(o_readback_output_enable), 72'h1, "enable bit");
      check(72'(o_readback_edge_select), 72'(eb), "edge bit");
      pick();
      frame(24, {48'h0, mk(1'b0, a, d)}, 1'b1, a, d);
      r = rnd();
      frame(24, {48'h0, mk(1'b1, a, r[15:0])}, 1'b0, a, d);
      frame(10, {62'h0, r[9:0]}, 1'b0, a, d);
      frame(24, {48'h0, mk(1'b1, a, 16'h0)}, 1'b0, a, d);
      check(rx[23:0], {48'h0, mk(1'b1, a, mem[a])}, "readback");
      check(72'(oe), 72'h1, "output enabled in readback");
    end
    pick();
    b = a;
    frame(48, {24'h0, mk(1'b1, b, 16'h0), mk(1'b0, b, d)}, 1'b1, b, d);
    check(rx[23:0], {48'h0, mk(1'b1, b, 16'h0)}, "chain echo");
    pick();
    frame(30, {42'h0, mk(1'b0, a, d), 6'h15}, 1'b0, a, d);
    @(posedge i_ref_clk);
    #1;
    j = wr_cnt;
    host.noise(oe);
    repeat (20) @(posedge i_ref_clk);
    check(72'(oe), 72'h0, "output while deselected");
    check(72'(wr_cnt - j), 72'h0, "write while deselected");
    i_rst_n = 1'b0;
    repeat (4) @(posedge i_ref_clk);
    #1 i_rst_n = 1'b1;
    repeat (5) @(posedge i_ref_clk);
    check(72'(o_iface_sel), 72'(serial_if_pkg::IF_NONE), "type after reset");
    j = wr_cnt;
    r = rnd();
    i2c_cond(1'b0);
    i2c_byte(8'h92, oe);
    check(72'(oe), 72'h1, "address ack");
    i2c_byte(8'h05, oe);
    check(72'(oe), 72'h1, "command ack");
    i2c_byte(r[15:8], oe);
    check(72'(oe), 72'h1, "upper ack");
    i2c_byte(r[7:0], oe);
    check(72'(oe), 72'h1, "lower ack");
    i2c_cond(1'b1);
    repeat (4) @(posedge i_ref_clk);
    check(72'(wr_cnt - j), 72'h1, "i2c write count");
    check(72'(wr_a), 72'h05, "i2c write address");
    check(72'(wr_d), 72'(r[15:0]), "i2c write data");
    check(72'(o_iface_sel), 72'(serial_if_pkg::IF_I2C), "i2c type");
    i2c_cond(1'b0);
    i2c_byte(8'h94, oe);
    check(72'(oe), 72'h0, "foreign address ack");
    i2c_cond(1'b1);
    j = sr_cnt;
    i2c_cond(1'b0);
    i2c_byte(8'h00, oe);
    check(72'(oe), 72'h1, "general call ack");
    i2c_byte(8'h06, oe);
    check(72'(oe), 72'h1, "reset code ack");
    i2c_cond(1'b1);
    repeat (4) @(posedge i_ref_clk);
    check(72'(sr_cnt - j), 72'h1, "soft reset pulse");
    check(72'(o_sda_out), 72'h0, "open drain level");
    end_of_test();
  end
endmodule
`default_nettype wire
